// [hdl/cps_pkg.sv]
// Purpose: Shared constants and carriers of the converter pipeline sequencer
// Assumes: 32-bit AHB-Lite register bus, eight DAC and eight ADC pipelines
// Notes:   Byte offsets are word aligned; all reserved bits read as zero
package cps_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_LEN  = 8'h08;
  localparam logic [7:0] ADDR_BASE = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_RES  = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  // Command word fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_ARGC_LSB = 4;
  // Configuration fields
  localparam int CFG_CHAN_LSB   = 0;
  localparam int CFG_ADC_BIT    = 3;
  localparam int CFG_ENABLE_BIT = 4;
  localparam int CFG_IQ_BIT     = 5;
  localparam int CFG_DDR_BIT    = 6;
  localparam int CFG_STAGED_BIT = 7;
  // Command codes and their argument counts
  localparam logic [3:0] CMD_WRITE_MEM  = 4'h1;
  localparam logic [3:0] CMD_READ_MEM   = 4'h2;
  localparam logic [3:0] CMD_SYNC_SETUP = 4'h3;
  localparam logic [3:0] CMD_STOP       = 4'h4;
  localparam logic [3:0] CMD_LOCAL_TRIG = 4'h5;
  localparam logic [3:0] ARGC_WRITE_MEM  = 4'h5;
  localparam logic [3:0] ARGC_READ_MEM   = 4'h5;
  localparam logic [3:0] ARGC_SYNC_SETUP = 4'h2;
  localparam logic [3:0] ARGC_STOP       = 4'h0;
  localparam logic [3:0] ARGC_LOCAL_TRIG = 4'h1;
  // Response codes
  localparam logic [2:0] RESP_NONE     = 3'h0;
  localparam logic [2:0] RESP_OK       = 3'h1;
  localparam logic [2:0] RESP_ERR_CMD  = 3'h2;
  localparam logic [2:0] RESP_ERR_ARGS = 3'h3;
  localparam logic [2:0] RESP_ERR_EXEC = 3'h4;
  // Transfer limits and descriptor span in bytes
  localparam logic [31:0] BRAM_LIMIT = 32'h0002_0000;
  localparam logic [31:0] DDR_LIMIT  = 32'h0800_0000;
  localparam logic [31:0] DESC_SPAN  = 32'h0002_0000;
  // Reset values and the all-channels mask
  localparam logic [7:0] RST_CHAN_EN  = 8'h00;
  localparam logic [7:0] RST_FIFO_EN  = 8'h00;
  localparam logic [7:0] RST_FIFO_RST = 8'hff;
  localparam logic [7:0] ALL_CHANS    = 8'hff;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_CHECK = 5'b00010,
    S_SEQ   = 5'b00100,
    S_DESC  = 5'b01000,
    S_WAIT  = 5'b10000
  } cps_fsm_e;

  typedef struct packed {
    logic [7:0] dac_chan_en;
    logic [7:0] adc_chan_en;
    logic [7:0] dac_fifo_rst;
    logic [7:0] adc_fifo_rst;
    logic [7:0] dac_fifo_en;
    logic [7:0] adc_fifo_en;
    logic [2:0] stream_sel;
    logic       dac_clk_fabric;
    logic       adc_clk_fabric;
    logic       common_ch0_en;
    logic       complex_pair_enable;
    logic [7:0] ddr_chan_mask;
    logic [2:0] route_sel;
  } cps_pipe_s;

  typedef struct packed {
    logic        desc_valid;
    logic [31:0] desc_addr;
    logic [31:0] desc_len;
    logic        start;
    logic        cyclic;
    logic        stop;
  } cps_dma_s;
endpackage

// [hdl/cps_top.sv]
// Purpose: Converter pipeline sequencer with AHB-Lite command registers
// Assumes: Single clock; DMA engine and converter FIFOs are outside
// Notes:   A command is launched by writing the command word while idle
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module cps_top (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              desc_ready,
  input  wire logic              dma_done,
  input  wire logic              dma_err,
  input  wire logic              dac_tlast,
  output cps_pkg::cps_pipe_s     pipe,
  output cps_pkg::cps_dma_s      dma,
  output logic                   local_memory_trigger
);
  import cps_pkg::*;

  typedef struct packed {
    cps_fsm_e    fsm;
    logic [2:0]  step;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  cmd;
    logic [3:0]  argc;
    logic [7:0]  cfg;
    logic [31:0] len;
    logic [31:0] base;
    logic [31:0] rem;
    logic [31:0] cur;
    logic [2:0]  resp;
    logic [3:0]  echo;
    logic [3:0]  nvals;
    logic [31:0] result;
    logic        data_ready;
    logic        dac_sync;
    logic        adc_sync;
    logic        trig;
    cps_pipe_s   pipe;
    cps_dma_s    dma;
  } cps_state_s;

  cps_state_s s_q;
  cps_state_s s_d;

  logic [2:0] ch;
  logic       is_adc;
  logic       is_en;
  logic       is_ddr;
  logic       known;
  logic [3:0] exp_argc;
  logic       too_long;
  logic       unsync;
  logic [31:0] rd_word;
  logic [31:0] chunk;

  assign ch     = s_q.cfg[CFG_CHAN_LSB +: 3];
  assign is_adc = s_q.cfg[CFG_ADC_BIT];
  assign is_en  = s_q.cfg[CFG_ENABLE_BIT];
  assign is_ddr = s_q.cfg[CFG_DDR_BIT];
  assign unsync = (s_q.cmd == CMD_READ_MEM) ? !s_q.adc_sync : !s_q.dac_sync;
  assign chunk  = (s_q.rem > DESC_SPAN) ? DESC_SPAN : s_q.rem;

  always_comb begin
    known    = 1'b1;
    exp_argc = 4'h0;
    unique case (s_q.cmd)
      CMD_WRITE_MEM:  exp_argc = ARGC_WRITE_MEM;
      CMD_READ_MEM:   exp_argc = ARGC_READ_MEM;
      CMD_SYNC_SETUP: exp_argc = ARGC_SYNC_SETUP;
      CMD_STOP:       exp_argc = ARGC_STOP;
      CMD_LOCAL_TRIG: exp_argc = ARGC_LOCAL_TRIG;
      default:        known    = 1'b0;
    endcase
  end

  assign too_long = is_ddr ? (s_q.len > DDR_LIMIT) : (s_q.len > BRAM_LIMIT);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CMD:  rd_word = {24'h00_0000, s_q.argc, s_q.cmd};
      ADDR_CFG:  rd_word = {24'h00_0000, s_q.cfg};
      ADDR_LEN:  rd_word = s_q.len;
      ADDR_BASE: rd_word = s_q.base;
      ADDR_STAT: rd_word = {16'h0000, s_q.adc_sync, s_q.dac_sync, s_q.data_ready,
                            (s_q.fsm != S_IDLE), s_q.nvals, s_q.echo, 1'b0, s_q.resp};
      ADDR_RES:  rd_word = s_q.result;
      ADDR_MASK: rd_word = {24'h00_0000, s_q.pipe.ddr_chan_mask};
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d            = s_q;
    s_d.dma.start  = 1'b0;
    s_d.dma.stop   = 1'b0;
    s_d.trig       = 1'b0;
    if (s_q.dma.desc_valid && desc_ready) begin
      s_d.dma.desc_valid = 1'b0;
    end
    // Address phase: reads answer in the following data phase with no wait
    s_d.wr_pend = hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
    s_d.waddr   = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_d.hrdata = rd_word;
    end
    // Argument registers only change while idle so a running sequence is stable
    if (s_q.wr_pend && s_q.fsm == S_IDLE) begin
      unique case (s_q.waddr)
        ADDR_CFG:  s_d.cfg  = hwdata[7:0];
        ADDR_LEN:  s_d.len  = hwdata;
        ADDR_BASE: s_d.base = hwdata;
        default:   s_d.cfg  = s_q.cfg;
      endcase
    end

    unique case (s_q.fsm)
      S_IDLE: begin
        if (s_q.wr_pend && s_q.waddr == ADDR_CMD) begin
          s_d.cmd        = hwdata[CMD_CODE_LSB +: 4];
          s_d.argc       = hwdata[CMD_ARGC_LSB +: 4];
          s_d.resp       = RESP_NONE;
          s_d.nvals      = 4'h0;
          s_d.result     = 32'h0000_0000;
          s_d.data_ready = 1'b0;
          s_d.step       = 3'h0;
          s_d.fsm        = S_CHECK;
        end
      end
      S_CHECK: begin
        s_d.echo = s_q.cmd;
        s_d.rem  = s_q.len;
        s_d.cur  = s_q.base;
        s_d.fsm  = S_IDLE;
        if (!known) begin
          s_d.resp = RESP_ERR_CMD;
        end else if (s_q.argc != exp_argc) begin
          s_d.resp = RESP_ERR_ARGS;
        end else if ((s_q.cmd == CMD_WRITE_MEM || s_q.cmd == CMD_READ_MEM) && too_long) begin
          s_d.resp = RESP_ERR_EXEC;
        end else if (s_q.cmd == CMD_WRITE_MEM && !s_q.cfg[CFG_STAGED_BIT]) begin
          s_d.resp = RESP_ERR_EXEC;
        end else begin
          s_d.fsm = S_SEQ;
        end
      end
      S_SEQ: begin
        s_d.step = s_q.step + 3'h1;
        unique case (s_q.cmd)
          CMD_WRITE_MEM: begin
            if (is_ddr) begin
              s_d.pipe.ddr_chan_mask[ch] = 1'b1;
              s_d.pipe.route_sel = ch;
              s_d.dma.cyclic     = 1'b1;
              s_d.fsm            = S_DESC;
            end else if (s_q.dac_sync) begin
              s_d.pipe.stream_sel = ch;
              s_d.dma.cyclic      = 1'b0;
              s_d.fsm             = S_DESC;
            end else begin
              unique case (s_q.step)
                3'h0: begin
                  s_d.pipe.dac_chan_en[ch] = 1'b0;
                  s_d.pipe.stream_sel      = ch;
                end
                3'h1: s_d.pipe.dac_fifo_rst[ch] = 1'b1;
                3'h2: s_d.pipe.dac_fifo_rst[ch] = 1'b0;
                default: begin
                  s_d.pipe.dac_fifo_en[ch] = 1'b1;
                  s_d.dma.cyclic           = 1'b1;
                  s_d.fsm                  = S_DESC;
                end
              endcase
            end
          end
          CMD_READ_MEM: begin
            s_d.dma.cyclic = 1'b0;
            unique case (s_q.step)
              3'h0: begin
                s_d.pipe.stream_sel          = ch;
                s_d.pipe.complex_pair_enable = s_q.cfg[CFG_IQ_BIT];
                if (s_q.adc_sync) begin
                  s_d.fsm = S_DESC;
                end
              end
              3'h1: s_d.pipe.adc_fifo_rst[ch] = 1'b1;
              3'h2: s_d.pipe.adc_fifo_rst[ch] = 1'b0;
              3'h3: s_d.pipe.adc_fifo_en[ch]  = 1'b1;
              default: begin
                s_d.pipe.adc_chan_en[ch] = 1'b1;
                s_d.fsm                  = S_DESC;
              end
            endcase
          end
          CMD_SYNC_SETUP: begin
            if (is_en) begin
              unique case (s_q.step)
                3'h0: begin
                  if (is_adc) s_d.pipe.adc_fifo_en = RST_FIFO_EN;
                  else        s_d.pipe.dac_fifo_en = RST_FIFO_EN;
                end
                3'h1: begin
                  if (is_adc) s_d.pipe.adc_fifo_rst = ALL_CHANS;
                  else        s_d.pipe.dac_fifo_rst = ALL_CHANS;
                end
                3'h2: begin
                  // ADC common enable waits for the local trigger after sync
                  if (is_adc) begin
                    s_d.pipe.adc_clk_fabric = 1'b1;
                    s_d.adc_sync            = 1'b1;
                  end else begin
                    s_d.pipe.dac_clk_fabric = 1'b1;
                    s_d.pipe.common_ch0_en  = 1'b1;
                    s_d.dac_sync            = 1'b1;
                  end
                end
                3'h3: begin
                  if (is_adc) s_d.pipe.adc_fifo_rst = RST_CHAN_EN;
                  else        s_d.pipe.dac_fifo_rst = RST_CHAN_EN;
                end
                default: begin
                  if (is_adc) s_d.pipe.adc_fifo_en = ALL_CHANS;
                  else        s_d.pipe.dac_fifo_en = ALL_CHANS;
                  s_d.resp = RESP_OK;
                  s_d.fsm  = S_IDLE;
                end
              endcase
            end else begin
              unique case (s_q.step)
                3'h0: begin
                  if (is_adc) s_d.pipe.adc_clk_fabric = 1'b0;
                  else        s_d.pipe.dac_clk_fabric = 1'b0;
                  s_d.pipe.common_ch0_en = 1'b0;
                end
                3'h1: begin
                  if (is_adc) s_d.pipe.adc_chan_en = RST_CHAN_EN;
                  else        s_d.pipe.dac_chan_en = RST_CHAN_EN;
                end
                default: begin
                  if (is_adc) begin
                    s_d.pipe.adc_fifo_en = RST_FIFO_EN;
                    s_d.adc_sync         = 1'b0;
                  end else begin
                    s_d.pipe.dac_fifo_en = RST_FIFO_EN;
                    s_d.dac_sync         = 1'b0;
                  end
                  s_d.resp = RESP_OK;
                  s_d.fsm  = S_IDLE;
                end
              endcase
            end
          end
          CMD_STOP: begin
            // Clearing the mask lets the host pick a fresh channel set
            s_d.dma.stop               = 1'b1;
            s_d.pipe.ddr_chan_mask     = RST_CHAN_EN;
            s_d.resp                   = RESP_OK;
            s_d.fsm                    = S_IDLE;
          end
          default: begin
            s_d.trig                   = 1'b1;
            s_d.pipe.common_ch0_en     = 1'b1;
            s_d.resp                   = RESP_OK;
            s_d.fsm                    = S_IDLE;
          end
        endcase
      end
      S_DESC: begin
        if (!s_q.dma.desc_valid || desc_ready) begin
          if (s_q.rem == 32'h0000_0000) begin
            s_d.dma.start = 1'b1;
            if (s_q.cmd == CMD_WRITE_MEM && is_ddr) begin
              // Cyclic DDR playback never completes, so answer at start
              s_d.resp = RESP_OK;
              s_d.fsm  = S_IDLE;
            end else begin
              s_d.fsm = S_WAIT;
            end
          end else begin
            s_d.dma.desc_valid = 1'b1;
            s_d.dma.desc_addr  = s_q.cur;
            s_d.dma.desc_len   = chunk;
            s_d.cur            = s_q.cur + DESC_SPAN;
            s_d.rem            = s_q.rem - chunk;
          end
        end
      end
      default: begin
        if (dma_err) begin
          s_d.resp = RESP_ERR_EXEC;
          s_d.fsm  = S_IDLE;
        end else if (s_q.cmd == CMD_WRITE_MEM && s_q.dac_sync) begin
          if (dac_tlast) begin
            s_d.trig               = 1'b1;
            s_d.pipe.common_ch0_en = 1'b1;
            s_d.resp               = RESP_OK;
            s_d.fsm                = S_IDLE;
          end
        end else if (dma_done) begin
          s_d.resp = RESP_OK;
          s_d.fsm  = S_IDLE;
          if (s_q.cmd == CMD_WRITE_MEM) begin
            s_d.pipe.dac_chan_en[ch] = 1'b1;
          end else begin
            if (unsync) s_d.pipe.adc_fifo_en[ch] = 1'b0;
            // data ready after DMA, one value
            s_d.data_ready = 1'b1;
            s_d.nvals      = 4'h1;
            s_d.result     = s_q.len;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q                   <= '0;
      s_q.fsm               <= S_IDLE;
      s_q.hreadyout         <= 1'b1;
      s_q.pipe.dac_chan_en  <= RST_CHAN_EN;
      s_q.pipe.adc_chan_en  <= RST_CHAN_EN;
      s_q.pipe.dac_fifo_en  <= RST_FIFO_EN;
      s_q.pipe.adc_fifo_en  <= RST_FIFO_EN;
      s_q.pipe.dac_fifo_rst <= RST_FIFO_RST;
      s_q.pipe.adc_fifo_rst <= RST_FIFO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata               = s_q.hrdata;
  assign hreadyout            = s_q.hreadyout;
  assign hresp                = s_q.hresp;
  assign pipe                 = s_q.pipe;
  assign dma                  = s_q.dma;
  assign local_memory_trigger = s_q.trig;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence unsync_dac_pulse;
    pipe.dac_fifo_rst[ch] ##1 !pipe.dac_fifo_rst[ch] ##1 pipe.dac_fifo_en[ch];
  endsequence
  sequence dac_setup_walk;
    (pipe.dac_fifo_en == 8'h00) ##1 (pipe.dac_fifo_rst == 8'hff) ##1
    (pipe.dac_clk_fabric && pipe.common_ch0_en) ##1 (pipe.dac_fifo_rst == 8'h00) ##1
    (pipe.dac_fifo_en == 8'hff);
  endsequence

  bad_cmd_a: assert property (s_q.fsm == S_CHECK && !known |=> s_q.resp == RESP_ERR_CMD && s_q.fsm == S_IDLE) else $error("unknown command not refused");
  arg_count_a: assert property (s_q.fsm == S_CHECK && known && s_q.argc != exp_argc |=> s_q.resp == RESP_ERR_ARGS && !dma.start) else $error("argument count not checked");
  len_limit_a: assert property (s_q.fsm == S_CHECK && known && s_q.argc == exp_argc && s_q.cmd == CMD_READ_MEM && too_long |=> s_q.resp == RESP_ERR_EXEC) else $error("oversize read accepted");
  no_values_a: assert property ($rose(s_q.resp == RESP_OK) && s_q.echo != CMD_READ_MEM |-> s_q.nvals == 4'h0) else $error("values on a valueless command");
  read_value_a: assert property ($rose(s_q.resp == RESP_OK) && s_q.echo == CMD_READ_MEM |-> s_q.nvals == 4'h1 && s_q.result == s_q.len && s_q.data_ready) else $error("read result missing");
  desc_step_a: assert property (dma.desc_valid && desc_ready ##1 dma.desc_valid |-> dma.desc_addr == $past(dma.desc_addr) + DESC_SPAN) else $error("descriptor address step wrong");
  dac_pulse_a: assert property (s_q.fsm == S_SEQ && s_q.cmd == CMD_WRITE_MEM && !is_ddr && !s_q.dac_sync && s_q.step == 3'h1 |=> unsync_dac_pulse) else $error("DAC FIFO reset pulse wrong");
  dac_setup_a: assert property (s_q.fsm == S_SEQ && s_q.cmd == CMD_SYNC_SETUP && is_en && !is_adc && s_q.step == 3'h0 |=> dac_setup_walk) else $error("DAC sync setup order wrong");
  trig_common_a: assert property (s_q.fsm == S_WAIT && s_q.cmd == CMD_WRITE_MEM && s_q.dac_sync && dac_tlast && !dma_err |=> local_memory_trigger && pipe.common_ch0_en) else $error("trigger missing after last");
  sync_off_a: assert property (s_q.fsm == S_SEQ && s_q.cmd == CMD_SYNC_SETUP && !is_en && s_q.step == 3'h0 |=> !pipe.common_ch0_en ##2 (is_adc ? pipe.adc_fifo_en : pipe.dac_fifo_en) == 8'h00) else $error("sync disable incomplete");
  ddr_mask_a: assert property (s_q.fsm == S_SEQ && s_q.cmd == CMD_WRITE_MEM && is_ddr |=> pipe.ddr_chan_mask[ch] && pipe.route_sel == ch) else $error("DDR mask or route not set");
  read_fifo_a: assert property (s_q.fsm == S_WAIT && s_q.cmd == CMD_READ_MEM && !s_q.adc_sync && dma_done && !dma_err |=> !pipe.adc_fifo_en[ch]) else $error("ADC FIFO left on");
  exec_err_a: assert property (s_q.fsm == S_WAIT && dma_err |=> s_q.resp == RESP_ERR_EXEC && !s_q.data_ready) else $error("execution error not reported");
endmodule

// [tb/cps_dma_model.sv]
// Purpose: DMA engine stand-in facing the sequencer
// Assumes: One descriptor offered at a time
// Notes:   slow halves accept rate and stretches completion
`timescale 1ns/1ps
module cps_dma_model
  import cps_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire cps_dma_s dma,
  input  wire logic     slow,
  input  wire logic     fail,
  output logic          desc_ready,
  output logic          dma_done,
  output logic          dma_err,
  output logic          dac_tlast
);
  logic [3:0] cnt_q;
  logic       tog_q;
  // Slow mode accepts on every other cycle only
  assign desc_ready = dma.desc_valid & (~slow | tog_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (dma.stop) cnt_q <= 4'h0;
      else if (dma.start) cnt_q <= slow ? 4'hc : 4'h2;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
  // One-cycle pulses; a stop aborts a running transfer
  assign dma_done  = (cnt_q == 4'h1) & ~fail;
  assign dma_err   = (cnt_q == 4'h1) & fail;
  assign dac_tlast = dma_done;
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the converter pipeline sequencer
// Assumes: Zero-wait slave, DMA stand-in on the far side
// Notes:   Read expectations queue up and are judged in the data phase
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH %0t value differs", $time); end end
module tb_top;
  import cps_pkg::*;
  logic        hclk = 0, hresetn = 0, hwrite = 0, dph = 0, slow = 0, fail = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat, b = 0, len;
  logic        hreadyout, hresp, desc_ready, dma_done, dma_err, dac_tlast, trig, iq;
  logic [16:0] sv;
  logic [2:0]  ch;
  logic [63:0] exp_q[$], desc_q[$], e;
  cps_pipe_s   pipe, p;
  cps_dma_s    dma;
  logic [3:0]  ac [5] = '{ARGC_WRITE_MEM, ARGC_READ_MEM, ARGC_SYNC_SETUP, ARGC_STOP,
                         ARGC_LOCAL_TRIG};
  logic [31:0] lim [3] = '{BRAM_LIMIT + 32'h1, DDR_LIMIT + 32'h1, 32'h40};
  logic [7:0]  cf [3] = '{8'h80, 8'hc0, 8'h00};
  int          failures = 0, checks = 0, trig_n = 0;
  always #5 hclk = ~hclk;
  cps_top i_cps_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .desc_ready, .dma_done,
    .dma_err, .dac_tlast, .pipe, .dma, .local_memory_trigger(trig));
  cps_dma_model i_cps_dma_model (.hclk, .hresetn, .dma, .slow, .fail, .desc_ready,
    .dma_done, .dma_err, .dac_tlast);
  always @(posedge hclk) begin
    if (dph) begin
      e = exp_q.pop_front();
      `CHK(hrdata & e[63:32], e[31:0])
      `CHK(hresp, 1'b0)
    end
    if (trig) trig_n++;
    if (dma.desc_valid && desc_ready) begin
      e = desc_q.pop_front();
      `CHK({dma.desc_addr, dma.desc_len}, e)
    end
  end
  task automatic tally_and_finish;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wrdy;
    int n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin failures++; tally_and_finish; end
  endtask
  task automatic bus(input logic w, k, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wrdy;
    htrans <= 2'b00;
    hwdata <= d;
    dph <= k;
    wrdy;
    rdat = hrdata;
    dph <= 1'b0;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] x, m);
    exp_q.push_back({m, x});
    bus(0, 1, a, 0);
  endtask
  task automatic run(input logic [3:0] c, a, input logic [7:0] cfg, input logic [31:0] l);
    int n = 0;
    bus(1, 0, ADDR_BASE, b);
    bus(1, 0, ADDR_LEN, l);
    bus(1, 0, ADDR_CFG, {24'h0, cfg});
    bus(1, 0, ADDR_CMD, {24'h0, a, c});
    repeat (2) @(posedge hclk);
    do begin bus(0, 0, ADDR_STAT, 0); n++; end while (rdat[12] !== 1'b0 && n < 200);
    if (rdat[12] !== 1'b0) begin failures++; tally_and_finish; end
  endtask
  initial begin
    void'($urandom(32'h5b3803a6));
    repeat (5) @(posedge hclk);
    p = '0;
    p.dac_fifo_rst = RST_FIFO_RST;
    p.adc_fifo_rst = RST_FIFO_RST;
    `CHK(pipe, p)
    `CHK(dma, cps_dma_s'(0))
    hresetn <= 1'b1;
    for (int c = 6; c < 17; c++) begin
      run(c[3:0], 4'h0, 8'h0, 32'h0);
      ck(ADDR_STAT, {29'h0, RESP_ERR_CMD}, 32'h7);
      `CHK(pipe, p)
    end
    foreach (ac[i]) begin
      run(i[3:0] + 4'h1, ac[i] + 4'h1, 8'h80, 32'h10);
      ck(ADDR_STAT, {29'h0, RESP_ERR_ARGS}, 32'h7);
    end
    foreach (lim[i]) begin
      run(CMD_WRITE_MEM, ARGC_WRITE_MEM, cf[i], lim[i]);
      ck(ADDR_STAT, {29'h0, RESP_ERR_EXEC}, 32'h7);
    end
    ch = 3'($urandom);
    b = $urandom & 32'hfff0_0000;
    desc_q.push_back({b, BRAM_LIMIT});
    run(CMD_WRITE_MEM, ARGC_WRITE_MEM, 8'h80 | ch, BRAM_LIMIT);
    ck(ADDR_STAT, {24'h0, CMD_WRITE_MEM, 1'b0, RESP_OK}, 32'h1ff7);
    `CHK({pipe.dac_chan_en[ch], pipe.dac_fifo_en[ch], pipe.dac_fifo_rst[ch], pipe.stream_sel}, {3'b110, ch})
    run(CMD_STOP, ARGC_STOP, 8'h0, 0);
    desc_q.push_back({b, DESC_SPAN});
    desc_q.push_back({b + DESC_SPAN, 32'h1});
    run(CMD_WRITE_MEM, ARGC_WRITE_MEM, 8'hc0 | ch, DESC_SPAN + 32'h1);
    `CHK({pipe.ddr_chan_mask, pipe.route_sel}, {8'h1 << ch, ch})
    `CHK(dma.cyclic, 1'b1)
    run(CMD_STOP, ARGC_STOP, 8'h0, 0);
    slow <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      fail <= f[0];
      ch = 3'($urandom);
      iq = 1'($urandom);
      len = ($urandom & 32'hfff) + 32'h1;
      desc_q.push_back({b, len});
      run(CMD_READ_MEM, ARGC_READ_MEM, {2'b00, iq, 2'b01, ch}, len);
      if (f == 0) begin
        ck(ADDR_STAT, 32'h2121, 32'h3ff7);
        ck(ADDR_RES, len, 32'hffff_ffff);
        `CHK({pipe.complex_pair_enable, pipe.adc_fifo_en[ch], pipe.adc_chan_en[ch]}, {iq, 2'b01})
      end else ck(ADDR_STAT, 32'h4, 32'h7);
    end
    fail <= 1'b0;
    slow <= 1'b0;
    for (int a = 0; a < 2; a++) begin
      run(CMD_SYNC_SETUP, ARGC_SYNC_SETUP, {3'b000, 1'b1, a[0], 3'h0}, 0);
      sv = a ? {pipe.adc_fifo_en, pipe.adc_fifo_rst, pipe.adc_clk_fabric}
             : {pipe.dac_fifo_en, pipe.dac_fifo_rst, pipe.dac_clk_fabric};
      `CHK(sv, {ALL_CHANS, 8'h00, 1'b1})
      desc_q.push_back({b, 32'h40});
      if (a == 0) run(CMD_WRITE_MEM, ARGC_WRITE_MEM, 8'h80 | ch, 32'h40);
      else run(CMD_LOCAL_TRIG, ARGC_LOCAL_TRIG, 8'h08, 0);
      if (a == 1) void'(desc_q.pop_back());
      `CHK(pipe.common_ch0_en, 1'b1)
      `CHK(trig_n, a + 1)
      if (a == 0) `CHK(dma.cyclic, 1'b0)
      run(CMD_SYNC_SETUP, ARGC_SYNC_SETUP, {4'h0, a[0], 3'h0}, 0);
      sv = a ? {pipe.adc_chan_en, pipe.adc_fifo_en, pipe.adc_clk_fabric}
             : {pipe.dac_chan_en, pipe.dac_fifo_en, pipe.dac_clk_fabric};
      `CHK({sv, pipe.common_ch0_en}, 18'h0)
    end
    tally_and_finish;
  end
endmodule
